/* File: design/boot_loader.v */
// Purpose: Security word load, boot source choice, image load and check
// Assumes: Memory reads answer one cycle after the request
// Notes: Register port answers reads one cycle later
`include "boot_loader_consts.vh"
module boot_loader
#(
  parameter DELAY_CYC = `BOOT_DELAY_CYC,
  parameter NGPIO     = 16
)
(
  // Clock, reset, enable
  input  wire             mclk,
  input  wire             resetn,
  input  wire             ce,
  input  wire             pll_lock,
  // Register port
  input  wire [3:0]       addr,
  input  wire [31:0]      wdata,
  input  wire             wr,
  input  wire             rd,
  output reg  [31:0]      rdata_ff,
  // Boot memory read port (flash or OTP)
  output reg              mem_rd_ff,
  output reg              mem_otp_ff,
  output reg  [15:0]      mem_addr_ff,
  input  wire [7:0]       mem_byte,
  // OTP word read for security word
  output reg              otp_wrd_ff,
  input  wire [31:0]      otp_word,
  // OTP programming ports
  output reg  [15:0]      otp_prog_addr_ff,
  output reg  [31:0]      otp_prog_data_ff,
  output reg  [15:0]      otp_prog_ctrl_ff,
  output reg              otp_prog_stb_ff,
  // RAM write port
  output reg              ram_we_ff,
  output reg  [17:0]      ram_addr_ff,
  output reg  [7:0]       ram_data_ff,
  // Processor and security outputs
  output reg              cpu_run_ff,
  output reg  [17:0]      cpu_pc_ff,
  output reg              rom_bypass_ff,
  output reg              boot_err_ff,
  output reg              gpio_pulldown_ff,
  output reg              jtag_block_ff,
  output reg              link_block_ff,
  output reg              otp_redundant_ff,
  output reg              jtag_otp_block_ff
);
  localparam S_DELAY = 8'h01;
  localparam S_SEC   = 8'h02;
  localparam S_SECW  = 8'h04;
  localparam S_SIZE  = 8'h08;
  localparam S_PROG  = 8'h10;
  localparam S_CRC   = 8'h20;
  localparam S_CHECK = 8'h40;
  localparam S_RUN   = 8'h80;

  reg  [7:0]  state_ff;
  reg  [31:0] cnt_ff;
  reg  [31:0] sec_ff;
  reg  [31:0] size_ff;
  reg  [31:0] crcw_ff;
  reg  [31:0] bytes_ff;
  reg  [1:0]  bidx_ff;
  reg         pend_ff;
  reg         reject_ff;
  reg  [15:0] paddr_ff;
  reg  [31:0] pdata_ff;
  wire [31:0] crc_val;
  wire        byte_in;
  wire        crc_step;
  wire [31:0] total_bytes;
  wire [31:0] status;

  // Sector containing a programming address
  function [1:0] sector_of;
    input [15:0] a;
    begin
      sector_of = a[10:9];
    end
  endfunction

  function locked;
    input [31:0] s;
    input [15:0] a;
    begin
      if (s[`SEC_MASTER_LOCK])
        locked = 1'b1;
      else if (a == `OTP_SEC_ADDR)
        locked = 1'b0;
      else
        locked = s[`SEC_LOCK_LO + sector_of(a)];
    end
  endfunction

  assign byte_in     = pend_ff;
  assign crc_step    = byte_in & ((state_ff == S_SIZE) |
                                  (state_ff == S_PROG));
  assign total_bytes = {size_ff[29:0], 2'b00};
  assign status      = {27'h0, reject_ff, sec_ff[`SEC_SECURE_BOOT],
                        boot_err_ff, cpu_run_ff,
                        (state_ff != S_RUN)};

  crc_byte u_crc
  (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .init   (state_ff == S_DELAY),
    .step   (crc_step),
    .din    (mem_byte),
    .crc_ff (crc_val)
  );

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_ff          <= S_DELAY;
      cnt_ff            <= 32'h0;
      sec_ff            <= 32'h0;
      size_ff           <= 32'h0;
      crcw_ff           <= 32'h0;
      bytes_ff          <= 32'h0;
      bidx_ff           <= 2'b00;
      pend_ff           <= 1'b0;
      reject_ff         <= 1'b0;
      paddr_ff          <= 16'h0;
      pdata_ff          <= 32'h0;
      rdata_ff          <= 32'h0;
      mem_rd_ff         <= 1'b0;
      mem_otp_ff        <= 1'b0;
      mem_addr_ff       <= 16'h0;
      otp_wrd_ff        <= 1'b0;
      otp_prog_addr_ff  <= 16'h0;
      otp_prog_data_ff  <= 32'h0;
      otp_prog_ctrl_ff  <= 16'h0;
      otp_prog_stb_ff   <= 1'b0;
      ram_we_ff         <= 1'b0;
      ram_addr_ff       <= 18'h0;
      ram_data_ff       <= 8'h0;
      cpu_run_ff        <= 1'b0;
      cpu_pc_ff         <= 18'h0;
      rom_bypass_ff     <= 1'b0;
      boot_err_ff       <= 1'b0;
      gpio_pulldown_ff  <= 1'b1;
      jtag_block_ff     <= 1'b0;
      link_block_ff     <= 1'b0;
      otp_redundant_ff  <= 1'b0;
      jtag_otp_block_ff <= 1'b0;
    end
    else if (ce)
    begin
      gpio_pulldown_ff <= 1'b0;
      mem_rd_ff        <= 1'b0;
      otp_wrd_ff       <= 1'b0;
      ram_we_ff        <= 1'b0;
      otp_prog_stb_ff  <= 1'b0;
      pend_ff          <= mem_rd_ff;
      // Register port
      rdata_ff <= 32'h0;
      if (rd)
      begin
        case (addr)
          `REG_SECURITY:  rdata_ff <= sec_ff;
          `REG_STATUS:    rdata_ff <= status;
          `REG_PROG_ADDR: rdata_ff <= {16'h0, paddr_ff};
          `REG_PROG_DATA: rdata_ff <= pdata_ff;
          `REG_USER_ID:   rdata_ff <= {22'h0,
                            sec_ff[`SEC_UID_HI:`SEC_UID_LO]};
          default:        rdata_ff <= 32'h0;
        endcase
      end
      if (wr)
      begin
        case (addr)
          `REG_SECURITY:
            sec_ff[`SEC_GP_HI:`SEC_GP_LO] <=
              wdata[`SEC_GP_HI:`SEC_GP_LO];
          `REG_PROG_ADDR: paddr_ff <= wdata[15:0];
          `REG_PROG_DATA: pdata_ff <= wdata;
          `REG_CONTROL:
          begin
            if (locked(sec_ff, paddr_ff))
              reject_ff <= 1'b1;
            else
            begin
              otp_prog_addr_ff <= paddr_ff;
              otp_prog_data_ff <= pdata_ff;
              otp_prog_ctrl_ff <= wdata[15:0];
              otp_prog_stb_ff  <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      case (state_ff)
        S_DELAY:
        begin
          if (pll_lock)
          begin
            if (cnt_ff >= DELAY_CYC - 1)
            begin
              state_ff   <= S_SEC;
              otp_wrd_ff <= 1'b1;
            end
            else
              cnt_ff <= cnt_ff + 32'h1;
          end
        end
        S_SEC:
          state_ff <= S_SECW;
        S_SECW:
        begin
          sec_ff            <= otp_word;
          jtag_block_ff     <= otp_word[`SEC_JTAG_OFF];
          link_block_ff     <= otp_word[`SEC_LINK_OFF];
          otp_redundant_ff  <= otp_word[`SEC_REDUNDANT];
          jtag_otp_block_ff <= otp_word[`SEC_JTAG_OTP_OFF];
          mem_otp_ff        <= otp_word[`SEC_SECURE_BOOT];
          rom_bypass_ff     <= otp_word[`SEC_SECURE_BOOT];
          mem_addr_ff       <= 16'h0;
          mem_rd_ff         <= 1'b1;
          bidx_ff           <= 2'b00;
          state_ff          <= S_SIZE;
        end
        S_SIZE:
        begin
          if (byte_in)
          begin
            bidx_ff                 <= bidx_ff + 2'b01;
            size_ff[bidx_ff*8 +: 8] <= mem_byte;
            mem_addr_ff             <= mem_addr_ff + 16'h1;
            mem_rd_ff               <= 1'b1;
            if (bidx_ff == 2'b11)
            begin
              // Empty program goes straight to the checksum bytes
              if (size_ff[23:0] == 24'h0 && mem_byte == 8'h00)
                state_ff <= S_CRC;
              else
                state_ff <= S_PROG;
            end
          end
        end
        S_PROG:
        begin
          if (byte_in)
          begin
            bidx_ff     <= bidx_ff + 2'b01;
            ram_we_ff   <= 1'b1;
            ram_addr_ff <= bytes_ff[17:0];
            ram_data_ff <= mem_byte;
            bytes_ff    <= bytes_ff + 32'h1;
            mem_addr_ff <= mem_addr_ff + 16'h1;
            mem_rd_ff   <= 1'b1;
            // Leave on the last program byte so no checksum byte is stored
            if (bytes_ff + 32'h1 >= total_bytes)
              state_ff <= S_CRC;
          end
        end
        S_CRC:
        begin
          if (byte_in)
          begin
            bidx_ff                 <= bidx_ff + 2'b01;
            crcw_ff[bidx_ff*8 +: 8] <= mem_byte;
            if (bidx_ff == 2'b11)
              state_ff <= S_CHECK;
            else
            begin
              mem_addr_ff <= mem_addr_ff + 16'h1;
              mem_rd_ff   <= 1'b1;
            end
          end
        end
        S_CHECK:
        begin
          state_ff <= S_RUN;
          if (crcw_ff == `CRC_BYPASS || crcw_ff == ~crc_val)
          begin
            cpu_run_ff <= 1'b1;
            cpu_pc_ff  <= 18'h0;
          end
          else
            boot_err_ff <= 1'b1;
        end
        S_RUN: ;
        default: state_ff <= S_DELAY;
      endcase
    end
  end
endmodule

/* File: design/boot_loader_consts.vh */
// Purpose: Constants for the boot and security configuration loader
// Assumes: 100 MHz mclk
// Notes: Rule overview follows
`ifndef BOOT_LOADER_CONSTS_VH
`define BOOT_LOADER_CONSTS_VH
`define CLK_MHZ          100
`define BOOT_DELAY_US    15
`define BOOT_DELAY_CYC   (`BOOT_DELAY_US * `CLK_MHZ)
`define SEC_JTAG_OFF     0
`define SEC_LINK_OFF     1
`define SEC_SECURE_BOOT  5
`define SEC_REDUNDANT    7
`define SEC_LOCK_LO      8
`define SEC_MASTER_LOCK  12
`define SEC_JTAG_OTP_OFF 13
`define SEC_GP_LO        15
`define SEC_GP_HI        21
`define SEC_UID_LO       22
`define SEC_UID_HI       31
`define OTP_SEC_ADDR     16'hffff
`define OTP_SECTORS      4
`define OTP_ROWS         512
`define CRC_POLY         32'hedb88320
`define CRC_INIT         32'hffffffff
`define CRC_BYPASS       32'h0d15ab1e
`define REG_SECURITY     4'h0
`define REG_STATUS       4'h1
`define REG_CONTROL      4'h2
`define REG_PROG_ADDR    4'h3
`define REG_PROG_DATA    4'h4
`define REG_USER_ID      4'h5
`define ST_BUSY          0
`define ST_DONE          1
`define ST_ERROR         2
`define ST_OTP_BOOT      3
`define ST_PROG_REJECT   4
`endif

/* File: design/crc_byte.v */
// Purpose: One byte step of the reflected CRC-32, registered result
// Assumes: Step pulses once per byte
// Notes: Holds state when init and step are low
`include "boot_loader_consts.vh"
module crc_byte
(
  // Clock and control
  input  wire        mclk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        init,
  input  wire        step,
  // Data
  input  wire [7:0]  din,
  output reg  [31:0] crc_ff
);
  function [31:0] crc_next;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg     [31:0] t;
    begin
      t = c ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1)
        t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
      crc_next = t;
    end
  endfunction

  always @(posedge mclk)
  begin
    if (!resetn)
      crc_ff <= `CRC_INIT;
    else if (ce)
    begin
      if (init)
        crc_ff <= `CRC_INIT;
      else if (step)
        crc_ff <= crc_next(crc_ff, din);
    end
  end
endmodule

/* File: testbench/boot_loader_sva.sv */
// Purpose: Port checks for the boot loader
// Assumes: One clock, synchronous active-low reset
// Notes: Security word tracked from the OTP answer
module boot_loader_sva
#(
  parameter int DELAY_CYC = 1500
)
(
  // Clock and control
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        pll_lock,
  // Memory side
  input wire logic        mem_rd_ff,
  input wire logic        mem_otp_ff,
  input wire logic [15:0] mem_addr_ff,
  input wire logic        otp_wrd_ff,
  input wire logic [31:0] otp_word,
  input wire logic        otp_prog_stb_ff,
  input wire logic [15:0] otp_prog_addr_ff,
  // Load results
  input wire logic        ram_we_ff,
  input wire logic [17:0] ram_addr_ff,
  input wire logic        cpu_run_ff,
  input wire logic [17:0] cpu_pc_ff,
  input wire logic        boot_err_ff,
  input wire logic        rom_bypass_ff,
  input wire logic        gpio_pulldown_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  logic [31:0] sec_ff;
  logic [1:0]  sp_ff;
  logic        seen_ff;
  logic [15:0] nxt_a_ff;
  logic [17:0] ram_n_ff;
  int          lk_ff;
  // Security word, read order, write count, locked cycles
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      sp_ff    <= 2'h0;
      seen_ff  <= 1'b0;
      nxt_a_ff <= 16'h0;
      ram_n_ff <= 18'h0;
      lk_ff    <= 0;
    end
    else
    begin
      sp_ff    <= {sp_ff[0], otp_wrd_ff};
      seen_ff  <= seen_ff | sp_ff[0];
      if (sp_ff[0])
        sec_ff <= otp_word;
      if (mem_rd_ff)
        nxt_a_ff <= mem_addr_ff + 16'h1;
      if (ram_we_ff)
        ram_n_ff <= ram_n_ff + 18'h1;
      if (pll_lock && ce)
        lk_ff <= lk_ff + 1;
    end
  end
  property p_pull;
    disable iff (1'b0) !resetn |=> gpio_pulldown_ff;
  endproperty
  a_pull: assert property (p_pull)
    else $error("pulldown off");
  property p_wait;
    otp_wrd_ff |-> lk_ff >= DELAY_CYC;
  endproperty
  a_wait: assert property (p_wait)
    else $error("boot too early");
  property p_src;
    mem_rd_ff |-> seen_ff && mem_otp_ff == sec_ff[5];
  endproperty
  a_src: assert property (p_src)
    else $error("wrong boot source");
  property p_seq;
    mem_rd_ff |-> mem_addr_ff == nxt_a_ff;
  endproperty
  a_seq: assert property (p_seq)
    else $error("read out of order");
  property p_ram;
    ram_we_ff |-> ram_addr_ff == ram_n_ff;
  endproperty
  a_ram: assert property (p_ram)
    else $error("ram address wrong");
  property p_run;
    $rose(cpu_run_ff) |-> cpu_pc_ff == 18'h0 && !boot_err_ff
      && rom_bypass_ff == sec_ff[5];
  endproperty
  a_run: assert property (p_run)
    else $error("bad start");
  property p_err;
    $rose(boot_err_ff) |-> ##1 (boot_err_ff && !cpu_run_ff) [*4];
  endproperty
  a_err: assert property (p_err)
    else $error("error not held");
  property p_lock;
    otp_prog_stb_ff |-> !sec_ff[12] && (otp_prog_addr_ff == 16'hffff
      || !sec_ff[8 + otp_prog_addr_ff[10:9]]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked program");
  c_run: cover property ($rose(cpu_run_ff));
  c_err: cover property ($rose(boot_err_ff));
  c_prog: cover property (otp_prog_stb_ff);
endmodule

bind boot_loader boot_loader_sva #(.DELAY_CYC(DELAY_CYC)) chk (.*);

/* File: testbench/boot_mem_model.sv */
// Purpose: Boot memory and OTP word model
// Assumes: Answers one cycle after a request
// Notes: Outside answers the lines toggle
module boot_mem_model
(
  // Requests
  input wire logic        mclk,
  input wire logic        mem_rd_ff,
  input wire logic [15:0] mem_addr_ff,
  input wire logic        otp_wrd_ff,
  // Answers
  output logic [7:0]      mem_byte,
  output logic [31:0]     otp_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  img [0:63];
  logic [31:0] sec;
  logic [1:0]  wp;
  initial
  begin
    mem_byte = 8'h00;
    otp_word = 32'h0;
    wp = 2'h0;
  end
  always @(posedge mclk)
  begin
    wp       <= {wp[0], otp_wrd_ff};
    mem_byte <= mem_rd_ff ? img[mem_addr_ff[5:0]] : ~mem_byte;
    otp_word <= (otp_wrd_ff | wp[0]) ? sec : ~otp_word;
  end
endmodule

/* File: testbench/secure_boot_image_loader_bench.sv */
// Purpose: Boot, image check and register tests
// Assumes: Small boot delay
// Notes: Image is two words
`include "boot_loader_consts.vh"
module secure_boot_image_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, ce, pll_lock, wr, rd;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata_ff, otp_word, otp_prog_data_ff;
  logic [15:0] mem_addr_ff, otp_prog_addr_ff, otp_prog_ctrl_ff;
  logic [17:0] ram_addr_ff, cpu_pc_ff;
  logic [7:0]  mem_byte, ram_data_ff;
  logic        mem_rd_ff, mem_otp_ff, otp_wrd_ff, otp_prog_stb_ff;
  logic        ram_we_ff, cpu_run_ff, rom_bypass_ff, boot_err_ff;
  logic        gpio_pulldown_ff, jtag_block_ff, link_block_ff;
  logic        otp_redundant_ff, jtag_otp_block_ff;
  logic [7:0]  ram [0:63];
  logic [63:0] pgot;
  int          n_fail, n_compared, cyc, stb_n;
  boot_loader #(.DELAY_CYC(4)) uut (.*);
  boot_mem_model mdl (.*);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (ram_we_ff === 1'b1)
      ram[ram_addr_ff[5:0]] = ram_data_ff;
    if (otp_prog_stb_ff === 1'b1)
    begin
      stb_n++;
      pgot = {otp_prog_ctrl_ff, otp_prog_addr_ff, otp_prog_data_ff};
    end
    if (cyc == 3000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata_ff);
  endtask
  task prog(input logic [15:0] a);
    wr_reg(4'h3, {16'h0, a});
    wr_reg(4'h4, 32'h5a5aa5a5);
    wr_reg(4'h2, 32'h0007);
    repeat (4) @(posedge mclk);
  endtask
  function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] d);
    c = c ^ {24'h0, d};
    repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    return c;
  endfunction
  task boot(input logic [31:0] sec, input logic [1:0] kind);
    logic [31:0] c;
    int          i;
    c = `CRC_INIT;
    mdl.sec = sec;
    ram = '{default: 8'h00};
    for (i = 0; i < 12; i++)
    begin
      mdl.img[i] = i == 0 ? 8'h02 : i < 4 ? 8'h00 : 8'(8'h30 + i);
      c = crc8(c, mdl.img[i]);
    end
    c = kind == 2'd2 ? `CRC_BYPASS : ~c ^ {30'h0, kind};
    for (i = 0; i < 4; i++)
      mdl.img[12 + i] = c[8 * i +: 8];
    @(posedge mclk);
    resetn   <= 1'b0;
    pll_lock <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    #1 chk("pulldown", 1, gpio_pulldown_ff);
    repeat (10) @(posedge mclk);
    pll_lock <= 1'b1;
    i = 0;
    while (cpu_run_ff !== 1'b1 && boot_err_ff !== 1'b1 && i < 300)
    begin
      @(posedge mclk);
      i++;
    end
    #1 chk("run", kind != 2'd1, cpu_run_ff);
    chk("err", kind == 2'd1, boot_err_ff);
    chk("pc", 0, cpu_pc_ff);
    chk("romskip", sec[5], rom_bypass_ff);
    chk("blk", {sec[13], sec[7], sec[1:0]},
      {jtag_otp_block_ff, otp_redundant_ff, link_block_ff, jtag_block_ff});
    for (i = 0; i < 8; i++)
      chk("ram", mdl.img[i + 4], ram[i]);
    rd_chk(4'h1, {28'h0, sec[5], kind == 2'd1, kind != 2'd1, 1'b0});
  endtask
  initial
  begin
    resetn   = 1'b0;
    ce       = 1'b1;
    pll_lock = 1'b0;
    wr       = 1'b0;
    rd       = 1'b0;
    addr     = 4'h0;
    wdata    = 32'h0;
    boot(32'h00002183, 2'd0);
    wr_reg(4'h0, 32'hffffffff);
    rd_chk(4'h0, 32'h003fa183);
    rd_chk(4'hf, 32'h0);
    prog(16'h0200);
    chk("prog", {16'h7, 16'h200, 32'h5a5aa5a5}, pgot);
    prog(16'h0000);
    chk("nprog", 1, stb_n);
    rd_chk(4'h1, 32'h12);
    boot(32'h00001020, 2'd2);
    prog(16'hffff);
    chk("nprog", 1, stb_n);
    rd_chk(4'h1, 32'h1a);
    boot(32'hffc00000, 2'd1);
    rd_chk(4'h5, 32'h3ff);
    end_of_test;
  end
endmodule
